/* File: src/flash_guard.sv */
// flash protection, vector redirection and security gating
`timescale 1ns/10ps
`default_nettype none
module flash_guard
(
    input  wire logic                mclk,
    input  wire logic                reset,
    input  wire logic                ce,
    input  wire guard_pkg::bus_req_t req,
    input  wire logic [7:0]          mem_rdata,
    input  wire logic [7:0]          nv_prot_byte,
    input  wire logic [7:0]          nv_opt_byte,
    input  wire logic [63:0]         nv_key,
    input  wire logic                blank_done,
    input  wire logic                blank_ok,
    output logic [15:0]              mem_addr,
    output logic                     mem_rd,
    output logic                     mem_wr,
    output logic [7:0]               rd_data,
    output logic                     rd_valid,
    output logic                     secure,
    output logic                     debug_allow,
    output logic                     redirect_active,
    output logic                     prot_fault
);
    import guard_pkg::*;

    guard_state_t st;
    guard_state_t next_st;

    logic        prot_en;
    logic [16:0] prot_start;
    logic        flash_hit;
    logic        ram_hit;
    logic        reg_hit;
    logic        key_range;
    logic        key_wr;
    logic        wr_protected;
    logic        blocked;
    logic        key_match;
    logic        release_sec;

    // ========================================
    // helpers
    function automatic logic in_range
    (
        input logic [15:0] a,
        input logic [15:0] lo,
        input logic [15:0] hi
    );
        return (a >= lo) && (a <= hi);
    endfunction : in_range

    // ========================================
    // protection decode from working register
    assign prot_en = !st.working_protection_register[PDIS_BIT]; // see [R1]
    // region start: one block above size field times block
    assign prot_start = {1'b0, st.working_protection_register[7:1], 9'h000} + BLOCK_SIZE; // see [R1]

    // address classes
    assign flash_hit = in_range(req.addr, FLASH_BASE, FLASH_LAST);
    assign ram_hit = in_range(req.addr, RAM_BASE, RAM_LAST);
    assign reg_hit = in_range(req.addr, WORKING_OPTION_REGISTER_REG, WORKING_PROTECTION_REGISTER_REG);

    // vector block holds the key too, so one term covers both
    assign wr_protected = prot_en && flash_hit
                          && ({1'b0, req.addr} >= prot_start
                              || req.addr >= NVREG_BASE); // see [R2] see [R17]

    // ========================================
    // security state
    assign secure = st.working_option_register[SEC_HI:SEC_LO] != SEC_OPEN; // see [R10]
    assign debug_allow = !secure; // see [R11]

    // secure code passes; unsecured code and debug are stopped
    assign blocked = secure && (flash_hit || ram_hit)
                     && (!req.from_secure || req.bdc); // see [R7] see [R8]

    // ========================================
    // key window while key_access is set
    assign key_range = st.key_acc && in_range(req.addr, KEY_ADDR, KEY_LAST);
    // debug alone never feeds the key comparator
    assign key_wr = key_range && req.wr && req.from_secure
                    && !req.bdc; // see [R13] see [R16]

    backdoor_key u_key
    (
        .mclk       (mclk),
        .reset      (reset),
        .ce         (ce),
        .key_access (st.key_acc),
        .wr_strobe  (key_wr),
        .wr_index   (req.addr[2:0]),
        .wr_data    (req.wdata),
        .stored_key (nv_key),
        .key_enable (st.working_option_register[BACKDOOR_KEY_ENABLE_BIT]),
        .match      (key_match)
    );

    // ========================================
    // vector redirection on the address path
    vector_redirect u_redirect
    (
        .addr        (req.addr),
        .vec_fetch   (req.vec_fetch),
        .no_redirect (st.working_option_register[NORED_BIT]),
        .prot_en     (prot_en),
        .prot_start  (prot_start),
        .out_addr    (mem_addr),
        .active      (redirect_active)
    );

    // ========================================
    // strobes towards flash and RAM
    // combinational so the array sees them in the request cycle
    assign mem_rd = ce && req.rd && !blocked && !reg_hit; // see [R7]
    assign mem_wr = ce && req.wr && !blocked && !reg_hit
                    && !key_range && !wr_protected; // see [R1] see [R13]
    assign prot_fault = ce && req.wr && wr_protected
                        && !blocked && !key_range;

    // release by key match or by a clean blank check
    assign release_sec = key_match
                         || (blank_done && blank_ok); // see [R15] see [R19]

    // ========================================
    // next state
    always_comb
    begin
        next_st = st;
        next_st.rvalid = 1'b0;
        if (req.rd)
        begin
            next_st.rvalid = 1'b1;
            if (req.addr == WORKING_OPTION_REGISTER_REG)
                next_st.rdata = st.working_option_register;
            else if (req.addr == FLASH_CONFIGURATION_REGISTER_REG)
                next_st.rdata = 8'(st.key_acc) << KEY_ACCESS_BIT_BIT;
            else if (req.addr == WORKING_PROTECTION_REGISTER_REG)
                next_st.rdata = st.working_protection_register;
            else if (blocked)
                next_st.rdata = 8'h00; // see [R7]
            else
                next_st.rdata = mem_rdata; // see [R8]
        end
        // key_access only from secure code
        if (req.wr && req.addr == FLASH_CONFIGURATION_REGISTER_REG
            && req.from_secure && !req.bdc) // see [R16]
            next_st.key_acc = req.wdata[KEY_ACCESS_BIT_BIT];
        // application writes fall on the floor
        if (req.wr && req.addr == WORKING_PROTECTION_REGISTER_REG && req.bdc) // see [R18]
            next_st.working_protection_register = req.wdata;
        // sticky until reset; nothing sets security again
        if (release_sec)
            next_st.working_option_register[SEC_HI:SEC_LO] = SEC_OPEN; // see [R15] see [R19]
    end

    // ========================================
    // registers; reset reloads the nonvolatile copies
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            st.working_option_register <= nv_opt_byte; // see [R9]
            st.working_protection_register <= nv_prot_byte;
            st.key_acc <= 1'b0;
            st.rdata <= RDATA_RST;
            st.rvalid <= 1'b0;
        end
        else if (ce)
            st <= next_st;
    end

    assign rd_data = st.rdata;
    assign rd_valid = st.rvalid;

    // ========================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    property p_prot_f8;
        (st.working_protection_register == 8'hF8 && req.wr && req.addr >= 16'hFA00) |-> !mem_wr;
    endproperty
    a_prot_f8: assert property (p_prot_f8) // see [R1]
        else $error("write reached protected region");

    property p_prot_off;
        (st.working_protection_register[PDIS_BIT] && !blocked && !key_range && !reg_hit
         && ce && req.wr && flash_hit) |-> mem_wr;
    endproperty
    a_prot_off: assert property (p_prot_off) // see [R1]
        else $error("write blocked with protection disabled");

    property p_vec_prot;
        (prot_en && req.wr && req.addr >= VEC_BASE) |-> !mem_wr;
    endproperty
    a_vec_prot: assert property (p_vec_prot) // see [R2]
        else $error("vector write passed under protection");

    property p_reset_vec;
        (req.addr == 16'hFFFE && req.vec_fetch) |-> mem_addr == 16'hFFFE;
    endproperty
    a_reset_vec: assert property (p_reset_vec) // see [R5]
        else $error("reset vector was redirected");

    property p_redir_off;
        st.working_option_register[NORED_BIT] |-> !redirect_active && mem_addr == req.addr;
    endproperty
    a_redir_off: assert property (p_redir_off) // see [R3]
        else $error("redirect with no_redirect set");

    property p_redir_ffe0;
        (redirect_active && req.addr == 16'hFFE0)
            |-> mem_addr == 16'(prot_start[15:0] - 16'h0020);
    endproperty
    a_redir_ffe0: assert property (p_redir_ffe0) // see [R6]
        else $error("redirected vector at wrong address");

    property p_block_read;
        (ce && secure && req.rd && flash_hit && !req.from_secure)
            |=> rd_valid && rd_data == 8'h00 && secure;
    endproperty
    a_block_read: assert property (p_block_read) // see [R7]
        else $error("unsecured read of secure flash leaked data");

    property p_secure_read;
        (ce && req.rd && flash_hit && req.from_secure && !req.bdc)
            |=> rd_data == $past(mem_rdata);
    endproperty
    a_secure_read: assert property (p_secure_read) // see [R8]
        else $error("secure code read was altered");

    property p_sec_decode;
        secure == (st.working_option_register[1:0] != 2'h2);
    endproperty
    a_sec_decode: assert property (p_sec_decode) // see [R10]
        else $error("security decode wrong");

    property p_debug_gate;
        debug_allow |-> !secure;
    endproperty
    a_debug_gate: assert property (p_debug_gate) // see [R11]
        else $error("debug allowed while secure");

    property p_blank_release;
        (ce && blank_done && blank_ok) |=> !secure [*2];
    endproperty
    a_blank_release: assert property (p_blank_release) // see [R19]
        else $error("blank check did not release security");

    property p_working_protection_register_app;
        (ce && req.wr && !req.bdc && req.addr == WORKING_PROTECTION_REGISTER_REG) |=> $stable(st.working_protection_register);
    endproperty
    a_working_protection_register_app: assert property (p_working_protection_register_app) // see [R18]
        else $error("application changed protection register");

    property p_key_debug;
        (req.bdc && req.wr && key_range) |-> !key_wr && !mem_wr;
    endproperty
    a_key_debug: assert property (p_key_debug) // see [R16]
        else $error("debug write entered key path");

    property p_match_release;
        (ce && key_match) |=> !secure;
    endproperty
    a_match_release: assert property (p_match_release) // see [R15]
        else $error("key match did not release security");

    c_redirect: cover property (redirect_active && req.addr == 16'hFFE0);
    c_key_open: cover property (secure ##1 key_match ##1 !secure);
    c_blank_open: cover property (secure && blank_done && blank_ok);
    c_blocked: cover property (blocked && req.rd);

endmodule : flash_guard
`default_nettype wire

/* File: inc/guard_pkg.sv */
// package: constants, carriers and state types of the flash guard logic
//
// Functional notes
// [R1] protection active only with disable bit 0; size field sets region start
// [R2] reset and interrupt vectors are protected whenever any protection is on
// [R3] no_redirect bit 0 in the option byte enables vector redirection
// [R4] redirection acts only when some, but not all, flash is protected
// [R5] vectors 0xFFC0-0xFFFD redirect; reset vector 0xFFFE:FFFF never does
// [R6] redirected vector sits at same offset just below protected region
// [R7] secure: unsecured code or debug access to flash/RAM blocked, reads zero
// [R8] code running from secure memory has unrestricted access
// [R9] every reset copies nonvolatile option byte into working option register
// [R10] security off only when security bits are 1:0; all else secure
// [R11] on-chip debug cannot be enabled while secure
// [R12] backdoor key disabled when key enable bit is 0
// [R13] key_access set: key location writes captured, not sent to flash
// [R14] software writes key bytes ascending, never on adjacent bus cycles
// [R15] key_access cleared: matching key forces security bits to 1:0
// [R16] key entry accepted only from code running in secure memory
// [R17] protecting vector block also protects stored key bytes
// [R18] working protection register writable only by background debug
// [R19] blank check finding flash erased releases security until reset
// [R20] failed key comparison leaves security bits unchanged
package guard_pkg;

    // ========================================
    // memory map
    localparam logic [15:0] FLASH_BASE = 16'h8000;
    localparam logic [15:0] FLASH_LAST = 16'hFFFF;
    localparam logic [15:0] RAM_BASE   = 16'h0080;
    localparam logic [15:0] RAM_LAST   = 16'h047F;
    localparam logic [15:0] NVREG_BASE = 16'hFE00;
    localparam logic [15:0] KEY_ADDR   = 16'hFFB0;
    localparam logic [15:0] KEY_LAST   = 16'hFFB7;
    localparam logic [15:0] NONVOLATILE_PROTECTION_BYTE_ADR = 16'hFFBD;
    localparam logic [15:0] NONVOLATILE_OPTION_BYTE_ADR  = 16'hFFBF;
    localparam logic [15:0] VEC_BASE   = 16'hFFC0;
    localparam logic [15:0] VEC_LAST   = 16'hFFFD;
    localparam logic [15:0] VEC_SPAN   = 16'h0040;
    localparam logic [16:0] BLOCK_SIZE = 17'h00200;
    localparam logic [16:0] ADDR_SPAN  = 17'h10000;
    localparam logic [3:0]  KEY_LEN    = 4'h8;

    // ========================================
    // working registers in high page
    localparam logic [15:0] WORKING_OPTION_REGISTER_REG  = 16'h1840;
    localparam logic [15:0] FLASH_CONFIGURATION_REGISTER_REG = 16'h1841;
    localparam logic [15:0] WORKING_PROTECTION_REGISTER_REG = 16'h1842;
    localparam int          PDIS_BIT   = 0;
    localparam int          SEC_LO     = 0;
    localparam int          SEC_HI     = 1;
    localparam int          KEY_ACCESS_BIT_BIT = 5;
    localparam int          NORED_BIT  = 6;
    localparam int          BACKDOOR_KEY_ENABLE_BIT  = 7;
    localparam logic [1:0]  SEC_OPEN   = 2'h2;
    localparam logic [7:0]  RDATA_RST  = 8'h00;

    // ========================================
    // carriers and state
    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
        logic        wr;
        logic [7:0]  wdata;
        logic        from_secure;
        logic        bdc;
        logic        vec_fetch;
    } bus_req_t;

    typedef enum logic [1:0] {
        KEY_IDLE  = 2'h0,
        KEY_ENTRY = 2'h1,
        KEY_CHECK = 2'h3
    } key_phase_t;

    typedef struct packed {
        key_phase_t      phase;
        logic [3:0]      idx;
        logic [7:0][7:0] bytes;
        logic            bad;
        logic            last_wr;
        logic            match;
    } key_state_t;

    typedef struct packed {
        logic [7:0] working_option_register;
        logic [7:0] working_protection_register;
        logic       key_acc;
        logic [7:0] rdata;
        logic       rvalid;
    } guard_state_t;

endpackage : guard_pkg

/* File: src/vector_redirect.sv */
// vector redirection address remap
`timescale 1ns/10ps
`default_nettype none
module vector_redirect
(
    input  wire logic [15:0] addr,
    input  wire logic        vec_fetch,
    input  wire logic        no_redirect,
    input  wire logic        prot_en,
    input  wire logic [16:0] prot_start,
    output logic [15:0]      out_addr,
    output logic             active
);
    import guard_pkg::*;

    logic partial;

    // ========================================
    // some but not all of flash protected
    assign partial = prot_en
                     && (prot_start < ADDR_SPAN)
                     && (prot_start > {1'b0, FLASH_BASE}); // see [R4]

    // reset vector lies outside the window, so it never moves
    assign active = !no_redirect && partial && vec_fetch
                    && (addr >= VEC_BASE) && (addr <= VEC_LAST); // see [R3] see [R5]

    // same offset inside the span just under the protected start
    assign out_addr = active
        ? 16'(prot_start[15:0] - VEC_SPAN + {10'h000, addr[5:0]}) // see [R6]
        : addr;

endmodule : vector_redirect
`default_nettype wire

/* File: src/backdoor_key.sv */
// backdoor key capture and comparison
`timescale 1ns/10ps
`default_nettype none
module backdoor_key
(
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        ce,
    input  wire logic        key_access,
    input  wire logic        wr_strobe,
    input  wire logic [2:0]  wr_index,
    input  wire logic [7:0]  wr_data,
    input  wire logic [63:0] stored_key,
    input  wire logic        key_enable,
    output logic             match
);
    import guard_pkg::*;

    key_state_t st;
    key_state_t next_st;

    // ========================================
    // entry sequence; any slip poisons the attempt
    always_comb
    begin
        next_st = st;
        next_st.match = 1'b0;
        next_st.last_wr = wr_strobe;
        unique case (st.phase)
            KEY_IDLE:
            begin
                if (key_access)
                begin
                    next_st.phase = KEY_ENTRY;
                    next_st.idx = 4'h0;
                    next_st.bad = 1'b0;
                end
            end
            KEY_ENTRY:
            begin
                if (wr_strobe)
                begin
                    // order and spacing are the writer's duty; break = no match
                    if (st.last_wr || st.idx >= KEY_LEN
                        || wr_index != st.idx[2:0]) // see [R14]
                        next_st.bad = 1'b1;
                    else
                    begin
                        next_st.bytes[st.idx[2:0]] = wr_data; // see [R13]
                        next_st.idx = st.idx + 4'h1;
                    end
                end
                if (!key_access)
                    next_st.phase = KEY_CHECK;
            end
            KEY_CHECK:
            begin
                // a failed compare simply raises no match
                next_st.match = key_enable && !st.bad && st.idx == KEY_LEN
                                && st.bytes == stored_key; // see [R12] see [R15] see [R20]
                next_st.phase = KEY_IDLE;
            end
            default:
                next_st.phase = KEY_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            st <= '0;
        else if (ce)
            st <= next_st;
    end

    assign match = st.match;

    // ========================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    property p_fail_no_match;
        (ce && st.phase == KEY_CHECK && st.bad) |=> !match;
    endproperty
    a_fail_no_match: assert property (p_fail_no_match) // see [R20]
        else $error("poisoned key entry produced a match");

    property p_backdoor_key_enable_off;
        (ce && st.phase == KEY_CHECK && !key_enable) |=> !match;
    endproperty
    a_backdoor_key_enable_off: assert property (p_backdoor_key_enable_off) // see [R12]
        else $error("match with backdoor key disabled");

endmodule : backdoor_key
`default_nettype wire

/* File: sim/host_model.sv */
// far-side model: cpu bus master and debug host issuing byte requests
`timescale 1ns/10ps
`default_nettype none
module host_model
(
    input  wire logic               mclk,
    output var guard_pkg::bus_req_t req,
    output logic [7:0]              mem_rdata,
    input  wire logic [15:0]        mem_addr,
    input  wire logic               mem_rd,
    input  wire logic               mem_wr,
    input  wire logic [7:0]         rd_data,
    input  wire logic               rd_valid,
    input  wire logic               redirect_active,
    input  wire logic               prot_fault
);
    import guard_pkg::*;

    // ========================================
    // results of the latest transfer
    logic [15:0] s_addr;
    logic        s_rd;
    logic        s_wr;
    logic        s_fault;
    logic        s_redir;
    logic [7:0]  s_data;
    logic        s_leak;

    // idle bus at time zero
    initial
    begin
        req = '0;
        mem_rdata = 8'h00;
    end

    // strobe drops after the taking edge, so two requests never touch
    task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
                        input logic fs, input logic dbg, input logic vf);
        bus_req_t r;
        r = '{addr: a, rd: !w, wr: w, wdata: d, from_secure: fs, bdc: dbg, vec_fetch: vf};
        @(posedge mclk);
        req <= r;
        mem_rdata <= a[7:0] ^ 8'h3C;
        #1;
        s_addr = mem_addr;
        s_rd = mem_rd;
        s_wr = mem_wr;
        s_fault = prot_fault;
        s_redir = redirect_active;
        @(posedge mclk);
        req <= '0;
        // released data lines show no stale value
        mem_rdata <= ~(a[7:0] ^ 8'h3C);
        #1;
        s_data = rd_valid ? rd_data : 8'hEE;
    endtask : xfer

    // key bytes go ascending, one idle cycle apart; leak flags any array write
    task automatic key_entry(input logic [63:0] k, input logic dbg);
        s_leak = 1'b0;
        xfer(1'b1, FLASH_CONFIGURATION_REGISTER_REG, 8'h20, !dbg, dbg, 1'b0);
        for (int i = 0; i < 8; i++)
        begin
            xfer(1'b1, KEY_ADDR + 16'(i), k[8*i +: 8], !dbg, dbg, 1'b0);
            s_leak = s_leak | s_wr;
        end
        xfer(1'b1, FLASH_CONFIGURATION_REGISTER_REG, 8'h00, !dbg, dbg, 1'b0);
    endtask : key_entry
endmodule : host_model
`default_nettype wire

/* File: sim/tb_flash_guard.sv */
// self-checking bench of the flash guard
`timescale 1ns/10ps
`default_nettype none
module tb_flash_guard;
    import guard_pkg::*;

    // ========================================
    // signals
    localparam logic [63:0] KEY = 64'h0123456789ABCDEF;
    logic        mclk;
    logic        reset;
    logic        ce;
    logic [7:0]  nv_prot_byte;
    logic [7:0]  nv_opt_byte;
    logic        blank_done;
    logic        blank_ok;
    bus_req_t    req;
    logic [7:0]  mem_rdata;
    logic [15:0] mem_addr;
    logic        mem_rd;
    logic        mem_wr;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        secure;
    logic        debug_allow;
    logic        redirect_active;
    logic        prot_fault;
    int          n_mismatch;
    int          samples_checked;

    flash_guard flash_guard_inst (.mclk(mclk), .reset(reset), .ce(ce), .req(req),
        .mem_rdata(mem_rdata), .nv_prot_byte(nv_prot_byte), .nv_opt_byte(nv_opt_byte),
        .nv_key(KEY), .blank_done(blank_done), .blank_ok(blank_ok), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .rd_data(rd_data), .rd_valid(rd_valid),
        .secure(secure), .debug_allow(debug_allow), .redirect_active(redirect_active),
        .prot_fault(prot_fault));

    host_model host (.mclk(mclk), .req(req), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .rd_data(rd_data), .rd_valid(rd_valid),
        .redirect_active(redirect_active), .prot_fault(prot_fault));

    // 25 MHz clock
    always #20 mclk = ~mclk;

    // ========================================
    // tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rd(input logic [15:0] a, input logic fs, input logic dbg, input logic vf);
        host.xfer(1'b0, a, 8'h00, fs, dbg, vf);
    endtask : rd

    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic fs,
                      input logic dbg);
        host.xfer(1'b1, a, d, fs, dbg, 1'b0);
    endtask : wr

    // option and protection bytes are loaded while reset is held
    task automatic do_reset(input logic [7:0] opt, input logic [7:0] prot);
        @(posedge mclk);
        nv_opt_byte <= opt;
        nv_prot_byte <= prot;
        reset <= 1'b1;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        #1;
    endtask : do_reset

    task automatic blank_pulse(input logic ok);
        @(posedge mclk);
        blank_done <= 1'b1;
        blank_ok <= ok;
        @(posedge mclk);
        blank_done <= 1'b0;
        @(posedge mclk);
        #1;
    endtask : blank_pulse

    task automatic wait3;
        repeat (3) @(posedge mclk);
        #1;
    endtask : wait3

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    // watchdog: tests need well under a thousand cycles
    initial
    begin
        repeat (4000) @(posedge mclk);
        n_mismatch++;
        report_and_stop();
    end

    // ========================================
    // tests
    initial
    begin
        mclk = 1'b0;
        reset = 1'b1;
        ce = 1'b1;
        nv_prot_byte = 8'hF8;
        nv_opt_byte = 8'h03;
        blank_done = 1'b0;
        blank_ok = 1'b0;
        n_mismatch = 0;
        samples_checked = 0;
        // secure, key disabled, redirect on, 0xFA00..0xFFFF protected
        do_reset(8'h03, 8'hF8);
        rd(WORKING_OPTION_REGISTER_REG, 1'b0, 1'b1, 1'b0);
        chk(host.s_data, 8'h03);
        chk(secure, 1'b1);
        chk(debug_allow, 1'b0);
        rd(16'hFFE0, 1'b1, 1'b0, 1'b1);
        chk(host.s_addr, 16'hF9E0);
        chk(host.s_redir, 1'b1);
        rd(16'hFFFE, 1'b1, 1'b0, 1'b1);
        chk(host.s_addr, 16'hFFFE);
        rd(16'h9000, 1'b0, 1'b1, 1'b0);
        chk(host.s_rd, 1'b0);
        chk(host.s_data, 8'h00);
        wr(16'h0100, 8'h55, 1'b0, 1'b0);
        chk(host.s_wr, 1'b0);
        rd(16'h9000, 1'b1, 1'b0, 1'b0);
        chk(host.s_data, 8'h3C);
        wr(16'hFA00, 8'hAA, 1'b1, 1'b0);
        chk({host.s_wr, host.s_fault}, 2'b01);
        wr(16'hF9FF, 8'hAA, 1'b1, 1'b0);
        chk({host.s_wr, host.s_fault}, 2'b10);
        wr(16'hFFC4, 8'hAA, 1'b1, 1'b0);
        chk(host.s_fault, 1'b1);
        wr(KEY_ADDR, 8'hAA, 1'b1, 1'b0);
        chk(host.s_fault, 1'b1);
        host.key_entry(KEY, 1'b0);
        wait3();
        chk(secure, 1'b1);
        wr(WORKING_PROTECTION_REGISTER_REG, 8'hFF, 1'b1, 1'b0);
        rd(16'hFFE0, 1'b1, 1'b0, 1'b1);
        chk(host.s_redir, 1'b1);
        wr(WORKING_PROTECTION_REGISTER_REG, 8'h00, 1'b0, 1'b1);
        rd(16'hFFE0, 1'b1, 1'b0, 1'b1);
        chk(host.s_redir, 1'b0);
        wr(WORKING_PROTECTION_REGISTER_REG, 8'hFF, 1'b0, 1'b1);
        wr(16'hFA00, 8'hAA, 1'b1, 1'b0);
        chk(host.s_wr, 1'b1);
        blank_pulse(1'b0);
        chk(secure, 1'b1);
        blank_pulse(1'b1);
        chk(secure, 1'b0);
        chk(debug_allow, 1'b1);
        rd(16'h9000, 1'b0, 1'b1, 1'b0);
        chk(host.s_data, 8'h3C);
        $display("test protection and security done");
        // key enabled, redirect off
        do_reset(8'hC3, 8'hF8);
        rd(16'hFFE0, 1'b1, 1'b0, 1'b1);
        chk(host.s_addr, 16'hFFE0);
        host.key_entry(KEY ^ 64'h1, 1'b0);
        wait3();
        chk(secure, 1'b1);
        host.key_entry(KEY, 1'b1);
        wait3();
        chk(secure, 1'b1);
        host.key_entry(KEY, 1'b0);
        repeat (2) @(posedge mclk);
        #1;
        chk(secure, 1'b1);
        @(posedge mclk);
        #1;
        chk(secure, 1'b0);
        chk(host.s_leak, 1'b0);
        rd(WORKING_OPTION_REGISTER_REG, 1'b0, 1'b1, 1'b0);
        chk(host.s_data, 8'hC2);
        // frozen clock enable must swallow a debug protection write
        @(posedge mclk);
        ce <= 1'b0;
        wr(WORKING_PROTECTION_REGISTER_REG, 8'hFF, 1'b0, 1'b1);
        @(posedge mclk);
        ce <= 1'b1;
        wr(16'hFA00, 8'hAA, 1'b1, 1'b0);
        chk(host.s_fault, 1'b1);
        $display("test backdoor key done");
        // all four security codes
        for (int s = 0; s < 4; s++)
        begin
            do_reset({6'h00, 2'(s)}, 8'hFF);
            chk(secure, (s == 2) ? 1'b0 : 1'b1);
        end
        $display("test security codes done");
        report_and_stop();
    end
endmodule : tb_flash_guard
`default_nettype wire
